//--- design/tll_pkg.sv
// Package for the thermal limit lock and event clear block.
// Assumes a register-access front end delivering decoded write strobes.
`default_nettype none
package tll_pkg;
    localparam int CFG_W = 16;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_UPPER = 4'h2;
    localparam logic [3:0] ADDR_LOWER = 4'h3;
    localparam logic [3:0] ADDR_CRIT = 4'h4;
    localparam int BIT_HYST_LO = 9;
    localparam int BIT_HYST_HI = 10;
    localparam int BIT_PWRDN = 8;
    localparam int BIT_CRIT_LOCK = 7;
    localparam int BIT_WIN_LOCK = 6;
    localparam int BIT_CLEAR = 5;
    localparam int BIT_EVSTAT = 4;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] THR_RESET = 16'h0000;
    localparam logic [15:0] CFG_RW_MASK = 16'h003F;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_PULSE = 3'h2,
        ST_HOLD = 3'h4
    } tll_state_t;
endpackage
`default_nettype wire

//--- design/tll_wr_if.sv
// Interface carrying a decoded register write between the lock logic and a
// threshold store. Assumes one write strobe per clock.
`default_nettype none
interface tll_wr_if;
    logic we;
    logic [15:0] data;
    logic [15:0] q;
    modport ctrl (output we, output data, input q);
    modport store (input we, input data, output q);
endinterface
`default_nettype wire

//--- design/tll_thr_reg.sv
// One threshold register whose writes are gated by the controller.
// Assumes synchronous active-high reset stands for power-on reset.
`default_nettype none
module tll_thr_reg
    import tll_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    tll_wr_if.store wr
);
    logic [15:0] value;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            value <= THR_RESET;
        end else if (wr.we) begin
            value <= wr.data;
        end
    end

    assign wr.q = value;
endmodule
`default_nettype wire

//--- design/tll_top.sv
// Configuration lock bits, shutdown/hysteresis protection, event clear strobe.
// Assumes a register front end giving address, write data and one-cycle strobes.
`default_nettype none
// Contract
// - Critical lock reads 0 after reset; critical register writable while clear.
// - Critical lock set: critical threshold register never changes.
// - Critical lock reads 1 once set; only reset clears it.
// - Window lock reads 0 after reset; upper and lower writable while clear.
// - Window lock set: upper and lower boundary registers never change.
// - Window lock reads 1 once set; only reset clears it.
// - One ordinary write arms either lock.
// - Clear bit write-only; writing 0 does nothing.
// - Writing 1 to clear bit drops latched event in interrupt mode; a request in the cycle after one that gave a pulse gives none.
// - Clear bit position always reads 0.
// - Any lock set: power-down cannot be set, may be cleared.
// - Any lock set: hysteresis field frozen.
// - Timeout enabled: alert response command also clears event.
module tll_top
    import tll_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_WR_STB,
    input wire logic [3:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_ARA_STB,
    input wire logic I_TIMEOUT_DIS,
    input wire logic I_INT_MODE,
    input wire logic I_EVENT_STATUS,
    output logic [15:0] O_CONFIG,
    output logic [15:0] O_UPPER,
    output logic [15:0] O_LOWER,
    output logic [15:0] O_CRIT,
    output logic O_WR_ACK,
    output logic O_LOCK_ACTIVE,
    output logic O_POWER_DOWN,
    output logic [1:0] O_HYST_SEL,
    output logic O_EVENT_CLEAR
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic crit_threshold_lock;
    logic window_threshold_lock;
    logic sensor_power_down;
    logic [1:0] hysteresis_select;
    logic [BIT_EVSTAT-1:0] cfg_low;
    logic any_lock;
    logic cfg_wr;
    logic alert_clear_strobe;
    logic clear_req;
    tll_state_t state;
    tll_state_t next_state;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
        hit = (a == target);
    endfunction

    assign any_lock = crit_threshold_lock | window_threshold_lock;
    assign cfg_wr = I_WR_STB & hit(I_ADDR, ADDR_CONFIG);

    // ------------------------------------------------------------
    // Lock bits
    // ------------------------------------------------------------
    // crit lock
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            crit_threshold_lock <= 1'b0;
        end else if (cfg_wr && I_WDATA[BIT_CRIT_LOCK]) begin
            crit_threshold_lock <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            window_threshold_lock <= 1'b0;
        end else if (cfg_wr && I_WDATA[BIT_WIN_LOCK]) begin
            window_threshold_lock <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Protected configuration fields
    // ------------------------------------------------------------
    // power-down guard
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            sensor_power_down <= CFG_RESET[BIT_PWRDN];
        end else if (cfg_wr && (!any_lock || !I_WDATA[BIT_PWRDN])) begin
            sensor_power_down <= I_WDATA[BIT_PWRDN];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            hysteresis_select <= CFG_RESET[BIT_HYST_HI:BIT_HYST_LO];
        end else if (cfg_wr && !any_lock) begin
            hysteresis_select <= I_WDATA[BIT_HYST_HI:BIT_HYST_LO];
        end
    end

    // Low configuration bits kept for read-back
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            cfg_low <= CFG_RESET[BIT_EVSTAT-1:0];
        end else if (cfg_wr) begin
            cfg_low <= I_WDATA[BIT_EVSTAT-1:0] & CFG_RW_MASK[BIT_EVSTAT-1:0];
        end
    end

    // ------------------------------------------------------------
    // Threshold registers
    // ------------------------------------------------------------
    tll_wr_if up_if ();
    tll_wr_if lo_if ();
    tll_wr_if cr_if ();

    assign up_if.we = I_WR_STB & hit(I_ADDR, ADDR_UPPER) & ~window_threshold_lock;
    assign lo_if.we = I_WR_STB & hit(I_ADDR, ADDR_LOWER) & ~window_threshold_lock;
    assign cr_if.we = I_WR_STB & hit(I_ADDR, ADDR_CRIT) & ~crit_threshold_lock;
    assign up_if.data = I_WDATA;
    assign lo_if.data = I_WDATA;
    assign cr_if.data = I_WDATA;

    tll_thr_reg u_upper (.i_clk(I_CLK), .i_reset(I_RESET), .wr(up_if));
    tll_thr_reg u_lower (.i_clk(I_CLK), .i_reset(I_RESET), .wr(lo_if));
    tll_thr_reg u_crit (.i_clk(I_CLK), .i_reset(I_RESET), .wr(cr_if));

    // ------------------------------------------------------------
    // Event clear strobe
    // ------------------------------------------------------------
    // clear sources
    assign clear_req = (cfg_wr & I_WDATA[BIT_CLEAR])
        | (I_ARA_STB & ~I_TIMEOUT_DIS);

    // ------------------------------------------------------------
    // Clear pulse sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (clear_req) begin
                    next_state = ST_PULSE;
                end
            end
            ST_PULSE: begin
                next_state = clear_req ? ST_HOLD : ST_IDLE;
            end
            ST_HOLD: begin
                next_state = clear_req ? ST_PULSE : ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign alert_clear_strobe = (next_state == ST_PULSE);

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_EVENT_CLEAR <= 1'b0;
        end else begin
            O_EVENT_CLEAR <= 1'b0;
            if (alert_clear_strobe) begin
                O_EVENT_CLEAR <= I_INT_MODE;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // plain acknowledge
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_WR_ACK <= 1'b0;
        end else begin
            O_WR_ACK <= I_WR_STB;
        end
    end

    always_comb begin
        O_CONFIG = 16'h0000;
        O_CONFIG[BIT_HYST_HI:BIT_HYST_LO] = hysteresis_select;
        O_CONFIG[BIT_PWRDN] = sensor_power_down;
        O_CONFIG[BIT_CRIT_LOCK] = crit_threshold_lock;
        O_CONFIG[BIT_WIN_LOCK] = window_threshold_lock;
        O_CONFIG[BIT_CLEAR] = 1'b0;
        O_CONFIG[BIT_EVSTAT] = I_EVENT_STATUS;
        O_CONFIG[BIT_EVSTAT-1:0] = cfg_low;
    end

    assign O_UPPER = up_if.q;
    assign O_LOWER = lo_if.q;
    assign O_CRIT = cr_if.q;
    assign O_LOCK_ACTIVE = any_lock;
    assign O_POWER_DOWN = sensor_power_down;
    assign O_HYST_SEL = hysteresis_select;
endmodule
`default_nettype wire

//--- test/tll_chk_sva.sv
// Checker for the lock and clear block: locks, frozen fields, write acknowledge.
// Assumes it is bound to tll_top and sees only its ports.
`default_nettype none
module tll_chk
    import tll_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_WR_STB,
    input wire logic [3:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_ARA_STB,
    input wire logic I_TIMEOUT_DIS,
    input wire logic I_INT_MODE,
    input wire logic [15:0] O_CONFIG,
    input wire logic [15:0] O_UPPER,
    input wire logic [15:0] O_LOWER,
    input wire logic [15:0] O_CRIT,
    input wire logic O_WR_ACK,
    input wire logic O_LOCK_ACTIVE,
    input wire logic O_POWER_DOWN,
    input wire logic [1:0] O_HYST_SEL,
    input wire logic O_EVENT_CLEAR
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    sequence cfg_wr; I_WR_STB && I_ADDR == ADDR_CONFIG; endsequence
    logic clr_req;
    assign clr_req = (I_WR_STB && I_ADDR == ADDR_CONFIG && I_WDATA[BIT_CLEAR])
        || (I_ARA_STB && !I_TIMEOUT_DIS);
    wr_ack_a: assert property (I_WR_STB |=> O_WR_ACK)
        else $error("write not acknowledged");
    crit_frozen_a: assert property ($past(O_CONFIG[BIT_CRIT_LOCK]) |-> $stable(O_CRIT))
        else $error("locked critical threshold changed");
    win_frozen_a: assert property ($past(O_CONFIG[BIT_WIN_LOCK]) |->
        $stable(O_UPPER) && $stable(O_LOWER)) else $error("locked window changed");
    lock_sticky_a: assert property (
        (!$past(O_CONFIG[BIT_CRIT_LOCK]) || O_CONFIG[BIT_CRIT_LOCK])
        && (!$past(O_CONFIG[BIT_WIN_LOCK]) || O_CONFIG[BIT_WIN_LOCK]))
        else $error("lock bit cleared");
    lock_arm_a: assert property (cfg_wr ##0 I_WDATA[BIT_CRIT_LOCK] |=> O_LOCK_ACTIVE)
        else $error("single write did not arm lock");
    clear_zero_a: assert property (cfg_wr |=> O_CONFIG[BIT_CLEAR] == 1'b0)
        else $error("clear bit reads one");
    pdn_locked_a: assert property ($past(O_LOCK_ACTIVE) |-> !$rose(O_POWER_DOWN))
        else $error("power down set while locked");
    hyst_frozen_a: assert property ($past(O_LOCK_ACTIVE) |-> $stable(O_HYST_SEL))
        else $error("hysteresis changed while locked");
    clear_once_a: assert property (O_EVENT_CLEAR |=> !O_EVENT_CLEAR)
        else $error("clear pulse longer than one cycle");
    clear_cause_a: assert property (!clr_req |=> !O_EVENT_CLEAR)
        else $error("clear pulse without request");
    clear_mode_a: assert property (!I_INT_MODE |=> !O_EVENT_CLEAR)
        else $error("clear pulse outside interrupt mode");
    clear_arm_a: assert property (clr_req && I_INT_MODE && !$past(clr_req) |=> O_EVENT_CLEAR)
        else $error("clear request gave no pulse");
endmodule
`default_nettype wire

//--- test/tll_host.sv
// Host model issuing register writes and alert responses.
// Assumes requests start after a falling edge; released lines show inverted data.
`default_nettype none
module tll_host (
    input wire logic i_clk,
    output logic o_wr_stb,
    output logic [3:0] o_addr,
    output logic [15:0] o_wdata,
    output logic o_ara_stb
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {o_wr_stb, o_ara_stb, o_addr, o_wdata} = '0;
    task automatic req(input logic ara, input logic [3:0] a, input logic [15:0] d);
        @(negedge i_clk);
        o_ara_stb = ara;
        o_wr_stb = !ara;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk);
        {o_ara_stb, o_wr_stb} = 2'b00;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
endmodule
`default_nettype wire

//--- test/tll_top_test.sv
// Self-checking bench for the lock and clear block.
// Assumes the host model drives the write bus and alert response strobe.
`default_nettype none
module tll_top_test
    import tll_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, to_dis = 1'b0, int_mode = 1'b1;
    logic wr, ara, ack, lk, pdn, clr;
    logic ev = 1'b0;
    logic [3:0] addr;
    logic [15:0] wd, cfg, up, lo, crit;
    logic [1:0] hy;
    int bad_count = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    tll_host host (.i_clk(clk), .o_wr_stb(wr), .o_addr(addr), .o_wdata(wd), .o_ara_stb(ara));
    tll_top dut (.I_CLK(clk), .I_RESET(rst), .I_WR_STB(wr), .I_ADDR(addr), .I_WDATA(wd),
        .I_ARA_STB(ara), .I_TIMEOUT_DIS(to_dis), .I_INT_MODE(int_mode), .I_EVENT_STATUS(ev),
        .O_CONFIG(cfg), .O_UPPER(up), .O_LOWER(lo), .O_CRIT(crit), .O_WR_ACK(ack),
        .O_LOCK_ACTIVE(lk), .O_POWER_DOWN(pdn), .O_HYST_SEL(hy), .O_EVENT_CLEAR(clr));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_open();
        chk(cfg, 16'h0000);
        ev = 1'b1;
        host.req(1'b0, ADDR_CRIT, 16'h0050);
        chk({crit[14:0], ack}, 16'h00A1);
        chk(cfg, 16'h0010);
        ev = 1'b0;
        host.req(1'b0, ADDR_UPPER, 16'h0040);
        host.req(1'b0, ADDR_LOWER, 16'h0010);
        chk({up[7:0], lo[7:0]}, 16'h4010);
        host.req(1'b0, ADDR_CONFIG, 16'h0505);
        chk({hy, pdn, cfg[12:0]}, 16'hA505);
    endtask
    task automatic t_clear();
        host.req(1'b0, ADDR_CONFIG, 16'h0525);
        chk({cfg[14:0], clr}, 16'h0A0B);
        host.req(1'b0, ADDR_CONFIG, 16'h0505);
        chk(16'(clr), 16'h0000);
        host.req(1'b1, 4'h0, 16'h0000);
        chk(16'(clr), 16'h0001);
        int_mode = 1'b0;
        host.req(1'b0, ADDR_CONFIG, 16'h0525);
        chk(16'(clr), 16'h0000);
        {int_mode, to_dis} = 2'b11;
        host.req(1'b1, 4'h0, 16'h0000);
        chk(16'(clr), 16'h0000);
    endtask
    task automatic t_lock();
        host.req(1'b0, ADDR_CONFIG, 16'h0485);
        chk({lk, cfg[14:0]}, 16'h8485);
        host.req(1'b0, ADDR_CRIT, 16'h0099);
        chk({crit[14:0], ack}, 16'h00A1);
        host.req(1'b0, ADDR_UPPER, 16'h0077);
        chk(up, 16'h0077);
        host.req(1'b0, ADDR_CONFIG, 16'h0342);
        chk(cfg, 16'h04C2);
        host.req(1'b0, ADDR_LOWER, 16'h0001);
        chk(lo, 16'h0010);
        host.req(1'b0, ADDR_CONFIG, 16'h0000);
        chk(cfg, 16'h04C0);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(cfg, 16'h0000);
        host.req(1'b0, ADDR_CRIT, 16'h0011);
        chk(crit, 16'h0011);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_open();
        t_clear();
        t_lock();
        wrap_up();
    end
    initial begin
        #5000;
        bad_count++;
        wrap_up();
    end
endmodule
bind tll_top tll_chk u_chk (.*);
`default_nettype wire
